// ===== hw/pcgd_cfg.svh
// Purpose: Constants for the client-side byte datapath of the PCS.
// Assumes: One 125 MHz clock (312.5 MHz in 2.5G mode).
// Notes: Codes are the receive-side control values on the data lines.
`ifndef PCGD_CFG_SVH
`define PCGD_CFG_SVH

// Receive data codes; all but idle are driven with the error line high
`define PCGD_CODE_EXTEND 8'h0f
`define PCGD_CODE_LATE_ERR 8'h1f
`define PCGD_CODE_FALSE_CARRIER 8'h0e
`define PCGD_CODE_IDLE 8'h00

// Byte repetition counts per line speed
`define PCGD_REPEAT_100M 10
`define PCGD_REPEAT_10M 100

// Frame framing lengths expected from the client
`define PCGD_PREAMBLE_BYTES 8
`define PCGD_FCS_BYTES 4

// Clock rates in MHz, nominal and overclocked
`define PCGD_CLK_MHZ_1G 125
`define PCGD_CLK_MHZ_2G5 312

// Transmit buffer depth in entries
`define PCGD_TXBUF_DEPTH 2

`endif

// ===== hw/pcgd_pkg.sv
// Purpose: Types shared by both ends of the client byte datapath.
// Assumes: Constants come from pcgd_cfg.svh.
// Notes: Speed and receive symbol kinds are enumerations.
package pcgd_pkg;

  // Line speed selection
  typedef enum logic [1:0] {
    PCGD_SPD_10M = 2'h0,
    PCGD_SPD_100M = 2'h1,
    PCGD_SPD_1G = 2'h2
  } pcgd_speed_t;

  // Kind of received symbol handed over by the decoder
  typedef enum logic [2:0] {
    PCGD_RK_IDLE = 3'h0,
    PCGD_RK_DATA = 3'h1,
    PCGD_RK_DATA_ERR = 3'h2,
    PCGD_RK_EXTEND = 3'h3,
    PCGD_RK_LATE_ERR = 3'h4,
    PCGD_RK_FALSE_CARRIER = 3'h5
  } pcgd_rx_kind_t;

  // Transmit pacing states of the client end, one-hot
  typedef enum logic [1:0] {
    PCGD_TX_LOAD = 2'b01,
    PCGD_TX_HOLD = 2'b10
  } pcgd_tx_state_t;

  // Repeat count minus one for a speed; 2.5G forces no repetition
  function automatic logic [6:0] pcgd_rep_last(input pcgd_speed_t spd,
                                               input logic mode_2g5,
                                               input logic [6:0] r100,
                                               input logic [6:0] r10);
    logic [6:0] res;
    res = 7'h00;
    if (!mode_2g5) begin
      case (spd)
        PCGD_SPD_100M: res = r100 - 7'h01;
        PCGD_SPD_10M: res = r10 - 7'h01;
        default: res = 7'h00;
      endcase
    end
    return res;
  endfunction : pcgd_rep_last

endpackage : pcgd_pkg

// ===== hw/pcgd_if.sv
// Purpose: Byte-wide client interface between client and PCS ends.
// Assumes: Both ends on mclk; no clocking block.
// Notes: tx_ready is back-pressure from the PCS transmit buffer.
`timescale 1ns/100ps
`default_nettype none
interface pcgd_if;
  logic [7:0] tx_data; // Transmit byte
  logic tx_en; // Frame window
  logic client_tx_error; // Error injection
  logic tx_ready; // PCS can take a byte
  logic [7:0] rx_data; // Receive byte or code
  logic rx_dv; // Receive data valid
  logic client_rx_error; // Receive error
  logic [4:0] rx_cg_ind; // Code group reception indicators
  logic rx_disp_err; // Running disparity error
  logic rx_not_in_table; // Invalid code group

  // PCS end
  modport pcs (
    input tx_data, tx_en, client_tx_error,
    output tx_ready, rx_data, rx_dv, client_rx_error,
    output rx_cg_ind, rx_disp_err, rx_not_in_table
  );
  // Client end
  modport client (
    output tx_data, tx_en, client_tx_error,
    input tx_ready, rx_data, rx_dv, client_rx_error,
    input rx_cg_ind, rx_disp_err, rx_not_in_table
  );
endinterface : pcgd_if
`default_nettype wire

// ===== hw/pcgd_pcs_end.sv
// Purpose: PCS end of the client byte datapath, transmit and receive.
// Assumes: Decoder symbols arrive on mclk with valid/ready.
// Notes: Receive bytes are repeated per speed; transmit is buffered.
//
// Summary of operation
// [RULE1] 2.5G mode: one byte per overclocked cycle
// [RULE2] Client sends preamble with SFD, payload, FCS
// [RULE3] Transmit bytes carried as plain data
// [RULE4] Transmit error carried through to partner
// [RULE5] Receiving client tolerates lost preamble bytes
// [RULE6] Carrier extension: error high, code 0x0F
// [RULE7] Error during valid marks errored frame
// [RULE8] Late error in extension: code 0x1F
// [RULE9] False carrier signalled on corrupt start, noise
// [RULE10] Code group indicators aligned with data
// [RULE11] Disparity error pulses with offending group
// [RULE12] Not-in-table error same timing as disparity
// [RULE13] SGMII timing same; no 250/25 Mb/s
// [RULE14] Client holds transmit bytes ten cycles
// [RULE15] Client holds transmit bytes hundred cycles
// [RULE16] Client keeps interframe gap legal
// [RULE17] Transmit bytes are full eight bits
// [RULE18] Receive bytes repeated ten cycles at 100M
// [RULE19] Receive bytes repeated hundred cycles at 10M
// [RULE20] Receiving client samples each byte once
// [RULE21] False carrier: error, no valid, code
// [RULE22] Reset clears valid, error and status
`timescale 1ns/100ps
`default_nettype none
`include "pcgd_cfg.svh"
module pcgd_pcs_end
  import pcgd_pkg::*;
#(
  parameter int REP_100M = `PCGD_REPEAT_100M,
  parameter int REP_10M = `PCGD_REPEAT_10M,
  parameter int TXBUF_DEPTH = `PCGD_TXBUF_DEPTH
) (
  input wire logic mclk,
  input wire logic rstn,
  pcgd_if.pcs cif,
  input wire pcgd_speed_t speed,
  input wire logic mode_2g5,
  output logic [7:0] line_tx_data,
  output logic line_tx_en,
  output logic line_tx_err,
  output logic line_tx_valid,
  input wire logic line_tx_ready,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire pcgd_rx_kind_t line_rx_kind,
  input wire logic [7:0] line_rx_data,
  input wire logic [4:0] line_rx_cg_ind,
  input wire logic line_rx_disp_err,
  input wire logic line_rx_not_in_table,
  output logic speed_unsupported
);

  // Parameter checks: counts must fit the 7-bit repeat counter
  initial begin
    if (REP_100M < 1 || REP_100M > 127 || REP_10M < 1 || REP_10M > 127)
      $error("pcgd_pcs_end: repeat counts out of range");
    if (TXBUF_DEPTH != 2)
      $error("pcgd_pcs_end: transmit buffer has exactly two entries");
  end

  localparam logic [6:0] REP100_W = 7'(REP_100M);
  localparam logic [6:0] REP10_W = 7'(REP_10M);

  // Transmit buffer storage: {en, err, data}
  logic [9:0] tbuf_r [0:1];
  logic tbuf_wp_r; // Write slot
  logic tbuf_rp_r; // Read slot
  logic [1:0] tbuf_cnt_r; // Entries held
  logic tbuf_push; // Byte taken from client
  logic tbuf_pop; // Byte taken by line side

  // Receive repetition and held outputs
  logic [6:0] rep_last; // Last repeat index for speed
  logic [6:0] rep_cnt_r; // Cycles left on held byte
  logic [7:0] rx_data_r;
  logic rx_dv_r;
  logic rx_er_r;
  logic [4:0] rx_cg_r;
  logic rx_disp_r;
  logic rx_nit_r;
  logic rx_take; // New decoder symbol accepted
  logic spd_bad_r; // Unsupported rate seen in 2.5G

  // Rate selection; 2.5G ignores the slow rates entirely
  assign rep_last = pcgd_rep_last(speed, mode_2g5, REP100_W,
                                  REP10_W); // see [RULE13]

  // Flag a slow rate requested in 2.5G mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      spd_bad_r <= 1'b0;
    end else begin
      spd_bad_r <= mode_2g5 && (speed != PCGD_SPD_1G); // see [RULE13]
    end
  end
  assign speed_unsupported = spd_bad_r;

  // Transmit: every cycle offers one byte, taken only when room exists
  // Back-pressure rather than loss: the client must hold on tx_ready low
  assign cif.tx_ready = (tbuf_cnt_r != 2'h2);
  assign tbuf_push = cif.tx_ready; // see [RULE1]
  assign tbuf_pop = (tbuf_cnt_r != 2'h0) && line_tx_ready;

  // Buffer write; fields are never inspected, so no frame parsing
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tbuf_wp_r <= 1'b0;
    end else if (tbuf_push) begin
      tbuf_wp_r <= ~tbuf_wp_r;
    end
  end

  // Buffer data slots, no reset needed on payload
  always_ff @(posedge mclk) begin
    if (tbuf_push) begin
      // Error kept alongside data so the partner sees it
      tbuf_r[tbuf_wp_r] <= {cif.tx_en, cif.client_tx_error,
                            cif.tx_data}; // see [RULE3] see [RULE4]
    end
  end

  // Buffer read pointer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tbuf_rp_r <= 1'b0;
    end else if (tbuf_pop) begin
      tbuf_rp_r <= ~tbuf_rp_r;
    end
  end

  // Occupancy count
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tbuf_cnt_r <= 2'h0;
    end else if (tbuf_push && !tbuf_pop) begin
      tbuf_cnt_r <= tbuf_cnt_r + 2'h1;
    end else if (tbuf_pop && !tbuf_push) begin
      tbuf_cnt_r <= tbuf_cnt_r - 2'h1;
    end
  end

  // Line side view of the head entry; data comes from flip-flops
  assign line_tx_valid = (tbuf_cnt_r != 2'h0);
  assign line_tx_en = tbuf_r[tbuf_rp_r][9];
  // Error only counts inside the enable window
  assign line_tx_err = tbuf_r[tbuf_rp_r][9] &&
                       tbuf_r[tbuf_rp_r][8]; // see [RULE4]
  assign line_tx_data = tbuf_r[tbuf_rp_r][7:0]; // see [RULE17]

  // Receive: next symbol wanted when current byte has run its repeats
  assign line_rx_ready = (rep_cnt_r == 7'h00);
  assign rx_take = line_rx_ready && line_rx_valid;

  // Repeat counter; loads on a new symbol, counts down otherwise
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rep_cnt_r <= 7'h00;
    end else if (rx_take) begin
      rep_cnt_r <= rep_last; // see [RULE18] see [RULE19]
    end else if (rep_cnt_r != 7'h00) begin
      rep_cnt_r <= rep_cnt_r - 7'h01;
    end
  end

  // Output mapping per symbol kind; held unchanged while repeating
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_data_r <= `PCGD_CODE_IDLE;
      rx_dv_r <= 1'b0; // see [RULE22]
      rx_er_r <= 1'b0;
    end else if (rx_take) begin
      case (line_rx_kind)
        PCGD_RK_DATA: begin
          rx_data_r <= line_rx_data;
          rx_dv_r <= 1'b1;
          rx_er_r <= 1'b0;
        end
        PCGD_RK_DATA_ERR: begin
          // Errored frame byte keeps valid high
          rx_data_r <= line_rx_data;
          rx_dv_r <= 1'b1;
          rx_er_r <= 1'b1; // see [RULE7]
        end
        PCGD_RK_EXTEND: begin
          // Not an error, legal even on full duplex
          rx_data_r <= `PCGD_CODE_EXTEND;
          rx_dv_r <= 1'b0;
          rx_er_r <= 1'b1; // see [RULE6]
        end
        PCGD_RK_LATE_ERR: begin
          rx_data_r <= `PCGD_CODE_LATE_ERR;
          rx_dv_r <= 1'b0;
          rx_er_r <= 1'b1; // see [RULE8]
        end
        PCGD_RK_FALSE_CARRIER: begin
          // Corrupt start code or line noise
          rx_data_r <= `PCGD_CODE_FALSE_CARRIER;
          rx_dv_r <= 1'b0;
          rx_er_r <= 1'b1; // see [RULE9] see [RULE21]
        end
        default: begin
          rx_data_r <= `PCGD_CODE_IDLE;
          rx_dv_r <= 1'b0;
          rx_er_r <= 1'b0;
        end
      endcase
    end else if (rep_cnt_r == 7'h00) begin
      // Decoder starved: drop to idle rather than stretch a byte
      rx_data_r <= `PCGD_CODE_IDLE;
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
    end
  end

  // Status indicators registered with the same symbol as the data
  // Error pulses last one cycle, marking the offending group only
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_cg_r <= 5'h00; // see [RULE22]
      rx_disp_r <= 1'b0;
      rx_nit_r <= 1'b0;
    end else if (rx_take) begin
      rx_cg_r <= line_rx_cg_ind; // see [RULE10]
      rx_disp_r <= line_rx_disp_err; // see [RULE11]
      rx_nit_r <= line_rx_not_in_table; // see [RULE12]
    end else begin
      rx_cg_r <= (rep_cnt_r == 7'h00) ? 5'h00 : rx_cg_r;
      rx_disp_r <= 1'b0;
      rx_nit_r <= 1'b0;
    end
  end

  // Drive the client receive lines from flip-flops
  assign cif.rx_data = rx_data_r;
  assign cif.rx_dv = rx_dv_r;
  assign cif.client_rx_error = rx_er_r;
  assign cif.rx_cg_ind = rx_cg_r;
  assign cif.rx_disp_err = rx_disp_r;
  assign cif.rx_not_in_table = rx_nit_r;

endmodule : pcgd_pcs_end
`default_nettype wire

// ===== hw/pcgd_client_end.sv
// Purpose: Client end: paces transmit bytes, samples receive bytes.
// Assumes: Same mclk as the PCS end; user transmit side uses valid/ready, user receive side valid only.
// Notes: Framing (preamble, FCS, gap) is the user's job upstream.
`timescale 1ns/100ps
`default_nettype none
`include "pcgd_cfg.svh"
module pcgd_client_end
  import pcgd_pkg::*;
#(
  parameter int REP_100M = `PCGD_REPEAT_100M,
  parameter int REP_10M = `PCGD_REPEAT_10M
) (
  input wire logic mclk,
  input wire logic rstn,
  pcgd_if.client cif,
  input wire pcgd_speed_t speed,
  input wire logic mode_2g5,
  input wire logic user_tx_valid,
  output logic user_tx_ready,
  input wire logic [7:0] user_tx_data,
  input wire logic user_tx_en,
  input wire logic user_tx_err,
  output logic user_rx_valid,
  output logic [7:0] user_rx_data,
  output logic user_rx_dv,
  output logic user_rx_err
);

  // Counts must fit the 7-bit repeat counter
  initial begin
    if (REP_100M < 1 || REP_100M > 127 || REP_10M < 1 || REP_10M > 127)
      $error("pcgd_client_end: repeat counts out of range");
  end

  localparam logic [6:0] REP100_W = 7'(REP_100M);
  localparam logic [6:0] REP10_W = 7'(REP_10M);

  logic [6:0] rep_last; // Last repeat index
  pcgd_tx_state_t tx_st_r; // Pacing state
  logic [6:0] tx_cnt_r; // Cycles left on held byte
  logic tx_take; // User byte accepted this cycle
  logic [7:0] tx_data_r;
  logic tx_en_r;
  logic tx_er_r;
  logic [6:0] rx_cnt_r; // Position inside a repeated byte
  logic [7:0] rx_data_r;
  logic rx_dv_r;
  logic rx_er_r;
  logic rx_vld_r;

  assign rep_last = pcgd_rep_last(speed, mode_2g5, REP100_W, REP10_W);

  // Next user byte replaces the held one as its last copy is taken,
  // so no byte is offered one cycle more than its repeat count
  assign user_tx_ready = cif.tx_ready &&
                         (tx_st_r == PCGD_TX_LOAD || tx_cnt_r == 7'h00);
  assign tx_take = user_tx_valid && user_tx_ready;

  // Transmit pacing; a stall by the PCS freezes byte and count
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_st_r <= PCGD_TX_LOAD;
      tx_cnt_r <= 7'h00;
      tx_data_r <= 8'h00;
      tx_en_r <= 1'b0;
      tx_er_r <= 1'b0;
    end else if (tx_take) begin
      // Full byte, held for the speed's repeat count
      tx_data_r <= user_tx_data; // see [RULE17]
      tx_en_r <= user_tx_en; // see [RULE2] see [RULE16]
      tx_er_r <= user_tx_en && user_tx_err; // see [RULE4]
      tx_cnt_r <= rep_last; // see [RULE14] see [RULE15]
      tx_st_r <= PCGD_TX_HOLD;
    end else if (cif.tx_ready) begin
      case (tx_st_r)
        PCGD_TX_HOLD: begin
          // Count only cycles the PCS actually took
          if (tx_cnt_r != 7'h00) begin
            tx_cnt_r <= tx_cnt_r - 7'h01;
          end else begin
            // Last copy gone, nothing queued: show idle
            tx_en_r <= 1'b0;
            tx_er_r <= 1'b0;
            tx_st_r <= PCGD_TX_LOAD;
          end
        end
        default: tx_st_r <= PCGD_TX_LOAD;
      endcase
    end
  end

  // In LOAD with nothing offered the line shows idle
  assign cif.tx_data = tx_data_r;
  assign cif.tx_en = tx_en_r;
  assign cif.client_tx_error = tx_er_r;

  // Receive sampling: one sample per repeated byte, taken at its start
  // Phase is kept by counting, since repeats of equal bytes look alike
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_cnt_r <= 7'h00;
      rx_vld_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
    end else if (rx_cnt_r == 7'h00) begin
      rx_vld_r <= cif.rx_dv || cif.client_rx_error; // see [RULE20]
      rx_data_r <= cif.rx_data; // see [RULE5]
      rx_dv_r <= cif.rx_dv;
      rx_er_r <= cif.client_rx_error;
      rx_cnt_r <= (cif.rx_dv || cif.client_rx_error) ? rep_last : 7'h00;
    end else begin
      rx_vld_r <= 1'b0;
      rx_cnt_r <= rx_cnt_r - 7'h01;
    end
  end

  assign user_rx_valid = rx_vld_r;
  assign user_rx_data = rx_data_r;
  assign user_rx_dv = rx_dv_r;
  assign user_rx_err = rx_er_r;

endmodule : pcgd_client_end
`default_nettype wire

// ===== tb/pcgd_chk.sv
// Purpose: Concurrent checks on the client byte interface.
// Assumes: One clock mclk; rstn active low and synchronous.
// Notes: Repeat checks count runs of one symbol; idle runs are free.
`timescale 1ns/100ps
`default_nettype none
`include "pcgd_cfg.svh"
module pcgd_chk
  import pcgd_pkg::*;
#(
  parameter int REP_100M = `PCGD_REPEAT_100M,
  parameter int REP_10M = `PCGD_REPEAT_10M
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire pcgd_speed_t speed,
  input wire logic mode_2g5,
  input wire logic [7:0] tx_data,
  input wire logic tx_en,
  input wire logic client_tx_error,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_dv,
  input wire logic client_rx_error,
  input wire logic [4:0] rx_cg_ind,
  input wire logic rx_disp_err,
  input wire logic rx_not_in_table
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  int rep; // Copies of each symbol at this speed
  logic [9:0] rx_now; // Receive symbol with its flags
  logic [9:0] rx_last_r; // Receive symbol one cycle ago
  logic [15:0] rx_run_r; // Length of the receive run so far
  logic [9:0] tx_now; // Transmit byte with its flags
  logic [9:0] tx_last_r; // Last accepted transmit byte
  logic [15:0] tx_run_r; // Accepted copies of that byte

  // 2.5G mode forces single copies whatever the speed field says
  always_comb begin
    rep = 1;
    if (!mode_2g5 && speed == PCGD_SPD_100M) rep = REP_100M;
    if (!mode_2g5 && speed == PCGD_SPD_10M) rep = REP_10M;
  end
  assign rx_now = {rx_dv, client_rx_error, rx_data};
  assign tx_now = {tx_en, client_tx_error, tx_data};

  // Receive run length, restarted at each change
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_last_r <= 10'h000;
      rx_run_r <= 16'h0000;
    end else begin
      rx_last_r <= rx_now;
      rx_run_r <= (rx_now != rx_last_r) ? 16'h0001 : rx_run_r + 16'h0001;
    end
  end

  // Transmit run counts only cycles the buffer accepted
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_last_r <= 10'h000;
      tx_run_r <= 16'h0000;
    end else if (tx_ready) begin
      tx_last_r <= tx_now;
      tx_run_r <= (tx_now != tx_last_r) ? 16'h0001 : tx_run_r + 16'h0001;
    end
  end

  sequence s_lone_pulse(logic sig);
    sig ##1 !sig;
  endsequence

  a_reset_rx_quiet: assert property (
    $rose(rstn) |-> !rx_dv && !client_rx_error && rx_cg_ind == 5'h00
    && !rx_disp_err && !rx_not_in_table)
    else $error("receive side not quiet after reset");
  a_txerr_in_window: assert property (
    client_tx_error |-> tx_en)
    else $error("transmit error outside frame window");
  a_rx_err_codes: assert property (
    client_rx_error && !rx_dv |-> rx_data inside {`PCGD_CODE_EXTEND,
    `PCGD_CODE_LATE_ERR, `PCGD_CODE_FALSE_CARRIER})
    else $error("receive error without valid carries a bad code");
  a_tx_refused_hold: assert property (
    !tx_ready |=> $stable(tx_now))
    else $error("refused transmit byte not held");
  a_rx_repeat_count: assert property (
    rx_now != rx_last_r && (rx_last_r[9] || rx_last_r[8])
    |-> rx_run_r % rep == 0)
    else $error("receive symbol repeated a wrong number of times");
  a_tx_repeat_count: assert property (
    tx_ready && tx_now != tx_last_r && tx_last_r[9] |-> tx_run_r % rep == 0)
    else $error("transmit byte repeated a wrong number of times");
  a_disp_err_pulse: assert property (
    rep > 1 && rx_disp_err |-> s_lone_pulse(rx_disp_err))
    else $error("disparity error longer than one cycle");
  a_not_table_pulse: assert property (
    rep > 1 && rx_not_in_table |-> s_lone_pulse(rx_not_in_table))
    else $error("invalid code flag longer than one cycle");
endmodule : pcgd_chk
`default_nettype wire

// ===== tb/pcs_client_gmii_datapath_test.sv
// Purpose: Self-checking bench for both ends of the client datapath.
// Assumes: Repeat counts 2 and 3 stand in for ten and a hundred.
// Notes: Expected streams come from bench functions only.
`timescale 1ns/100ps
`default_nettype none
`include "pcgd_cfg.svh"
module pcs_client_gmii_datapath_test
  import pcgd_pkg::*;
;
  localparam int R100 = 2; // Short so the run stays brief
  localparam int R10 = 3;
  logic mclk = 1'b0, rstn = 1'b0, mode_2g5 = 1'b0, stall_on = 1'b0;
  pcgd_speed_t speed = PCGD_SPD_1G;
  logic line_tx_ready = 1'b1, line_rx_valid = 1'b0, saw_full = 1'b0;
  pcgd_rx_kind_t line_rx_kind = PCGD_RK_IDLE;
  logic [7:0] line_rx_data = 8'h00, user_tx_data = 8'h00, user_rx_data;
  logic [4:0] line_rx_cg_ind = 5'h00;
  logic line_rx_disp_err = 1'b0, line_rx_not_in_table = 1'b0;
  logic user_tx_valid = 1'b0, user_tx_en = 1'b0, user_tx_err = 1'b0;
  logic [7:0] line_tx_data;
  logic line_tx_en, line_tx_err, line_tx_valid, line_rx_ready;
  logic speed_unsupported, user_tx_ready, user_rx_valid, user_rx_dv;
  logic user_rx_err;
  logic [31:0] lfsr = 32'h490e1947, stall_s = 32'h490e1947;
  logic [8:0] tx_got[$], tx_exp[$]; // {error, byte}
  logic [9:0] rx_got[$], rx_exp[$]; // {valid, error, byte}
  pcgd_speed_t cfg_spd[4] = '{PCGD_SPD_1G, PCGD_SPD_100M, PCGD_SPD_10M,
                              PCGD_SPD_100M};
  logic cfg_2g5[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int err_count = 0, num_checks = 0;

  pcgd_if pcgd_if_inst ();
  pcgd_pcs_end #(.REP_100M(R100), .REP_10M(R10)) pcgd_pcs_end_inst (
    .mclk(mclk), .rstn(rstn), .cif(pcgd_if_inst), .speed(speed),
    .mode_2g5(mode_2g5), .line_tx_data(line_tx_data),
    .line_tx_en(line_tx_en), .line_tx_err(line_tx_err),
    .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
    .line_rx_valid(line_rx_valid), .line_rx_ready(line_rx_ready),
    .line_rx_kind(line_rx_kind), .line_rx_data(line_rx_data),
    .line_rx_cg_ind(line_rx_cg_ind), .line_rx_disp_err(line_rx_disp_err),
    .line_rx_not_in_table(line_rx_not_in_table),
    .speed_unsupported(speed_unsupported));
  pcgd_client_end #(.REP_100M(R100), .REP_10M(R10)) pcgd_client_end_inst (
    .mclk(mclk), .rstn(rstn), .cif(pcgd_if_inst), .speed(speed),
    .mode_2g5(mode_2g5), .user_tx_valid(user_tx_valid),
    .user_tx_ready(user_tx_ready), .user_tx_data(user_tx_data),
    .user_tx_en(user_tx_en), .user_tx_err(user_tx_err),
    .user_rx_valid(user_rx_valid), .user_rx_data(user_rx_data),
    .user_rx_dv(user_rx_dv), .user_rx_err(user_rx_err));
  pcgd_chk #(.REP_100M(R100), .REP_10M(R10)) pcgd_chk_inst (
    .mclk(mclk), .rstn(rstn), .speed(speed), .mode_2g5(mode_2g5),
    .tx_data(pcgd_if_inst.tx_data), .tx_en(pcgd_if_inst.tx_en),
    .client_tx_error(pcgd_if_inst.client_tx_error),
    .tx_ready(pcgd_if_inst.tx_ready), .rx_data(pcgd_if_inst.rx_data),
    .rx_dv(pcgd_if_inst.rx_dv),
    .client_rx_error(pcgd_if_inst.client_rx_error),
    .rx_cg_ind(pcgd_if_inst.rx_cg_ind),
    .rx_disp_err(pcgd_if_inst.rx_disp_err),
    .rx_not_in_table(pcgd_if_inst.rx_not_in_table));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ ({32{s[31]}} & 32'h04c11db7);
  endfunction : lfsr_next
  function automatic logic [7:0] rnd8();
    lfsr = lfsr_next(lfsr);
    return lfsr[7:0];
  endfunction : rnd8
  function automatic int rep_of(input pcgd_speed_t s, input logic m);
    if (m || s == PCGD_SPD_1G) return 1;
    return (s == PCGD_SPD_100M) ? R100 : R10;
  endfunction : rep_of
  // What the client end should hand on for each line symbol
  function automatic logic [9:0] rx_expect(input pcgd_rx_kind_t k,
                                           input logic [7:0] d);
    case (k)
      PCGD_RK_DATA: return {2'b10, d};
      PCGD_RK_DATA_ERR: return {2'b11, d};
      PCGD_RK_EXTEND: return {2'b01, `PCGD_CODE_EXTEND};
      PCGD_RK_LATE_ERR: return {2'b01, `PCGD_CODE_LATE_ERR};
      PCGD_RK_FALSE_CARRIER: return {2'b01, `PCGD_CODE_FALSE_CARRIER};
      default: return {2'b00, `PCGD_CODE_IDLE};
    endcase
  endfunction : rx_expect

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end
  // Far side of the line stalls three cycles in four when enabled
  always @(posedge mclk) begin
    stall_s <= lfsr_next(stall_s);
    line_tx_ready <= !stall_on || stall_s[1:0] == 2'h0;
  end
  // Accepted line bytes and user pulses, taken where settled
  always @(negedge mclk) begin
    if (line_tx_valid === 1'b1 && line_tx_ready && line_tx_en === 1'b1)
      tx_got.push_back({line_tx_err, line_tx_data});
    if (user_rx_valid === 1'b1)
      rx_got.push_back({user_rx_dv, user_rx_err, user_rx_data});
    if (pcgd_if_inst.tx_ready === 1'b0)
      saw_full = 1'b1;
  end

  task automatic do_reset(input pcgd_speed_t s, input logic m);
    rstn <= 1'b0;
    speed <= s;
    mode_2g5 <= m;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk("reset_low", 0, {pcgd_if_inst.rx_dv, pcgd_if_inst.client_rx_error,
        pcgd_if_inst.rx_cg_ind, user_rx_valid, line_tx_valid});
    chk("reset_ready", 3'b111, {pcgd_if_inst.tx_ready, line_rx_ready,
        user_tx_ready});
    @(posedge mclk);
  endtask : do_reset

  // Frame with full preamble, error on one payload byte, then FCS
  task automatic tx_frame(input int np, input int rep);
    logic [7:0] d;
    int i, n;
    tx_got.delete();
    tx_exp.delete();
    for (i = 0; i < np + 12; i++) begin
      d = (i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : rnd8();
      tx_exp.push_back({i == 9, d});
      user_tx_valid <= 1'b1;
      user_tx_data <= d;
      user_tx_en <= 1'b1;
      user_tx_err <= (i == 9);
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (user_tx_ready !== 1'b1 && n < 400);
      @(posedge mclk);
    end
    user_tx_valid <= 1'b0;
    user_tx_en <= 1'b0;
    user_tx_err <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((pcgd_if_inst.tx_en !== 1'b0 || line_tx_en !== 1'b0)
               && n < 3000);
    @(posedge mclk);
    chk("tx_count", tx_exp.size() * rep,
        tx_got.size());
    for (i = 0; i < tx_got.size(); i++)
      chk("tx_byte", tx_exp[i / rep],
          tx_got[i]);
  endtask : tx_frame

  // One line symbol with random status; interface checked next cycle
  task automatic rx_sym(input pcgd_rx_kind_t k, input logic [7:0] d);
    logic [7:0] st;
    int n;
    st = rnd8();
    line_rx_valid <= 1'b1;
    line_rx_kind <= k;
    line_rx_data <= d;
    {line_rx_not_in_table, line_rx_disp_err, line_rx_cg_ind} <= st[6:0];
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (line_rx_ready !== 1'b1 && n < 400);
    @(posedge mclk);
    line_rx_valid <= 1'b0;
    @(negedge mclk);
    chk("rx_status", st[6:0], {pcgd_if_inst.rx_not_in_table,
        pcgd_if_inst.rx_disp_err,
        pcgd_if_inst.rx_cg_ind});
    chk("rx_code", rx_expect(k, d), {pcgd_if_inst.rx_dv,
        pcgd_if_inst.client_rx_error,
        pcgd_if_inst.rx_data});
    if (k != PCGD_RK_IDLE)
      rx_exp.push_back(rx_expect(k, d));
    @(posedge mclk);
  endtask : rx_sym

  // Preamble cut to one byte, errored byte, extension, late error, noise
  task automatic rx_frame(input int rep);
    int i, n;
    rx_got.delete();
    rx_exp.delete();
    rx_sym(PCGD_RK_IDLE, 8'h00);
    rx_sym(PCGD_RK_DATA, 8'h55);
    rx_sym(PCGD_RK_DATA, 8'hd5);
    for (i = 0; i < 6; i++)
      rx_sym((i == 3) ? PCGD_RK_DATA_ERR : PCGD_RK_DATA, rnd8());
    rx_sym(PCGD_RK_EXTEND, 8'h00);
    rx_sym(PCGD_RK_LATE_ERR, 8'h00);
    rx_sym(PCGD_RK_IDLE, 8'h00);
    rx_sym(PCGD_RK_FALSE_CARRIER, 8'h00);
    n = 0;
    while (rx_got.size() < rx_exp.size() && n < 500) begin
      @(posedge mclk);
      n++;
    end
    repeat (rep + 2) @(posedge mclk);
    chk("rx_count", rx_exp.size(),
        rx_got.size());
    for (i = 0; i < rx_got.size(); i++)
      chk("rx_user", rx_exp[i], rx_got[i]);
  endtask : rx_frame

  // Each speed in turn, a fresh reset before each, stalls at 1G
  initial begin
    int c, rep;
    @(posedge mclk);
    for (c = 0; c < 4; c++) begin
      rep = rep_of(cfg_spd[c], cfg_2g5[c]);
      stall_on <= (c == 0);
      do_reset(cfg_spd[c], cfg_2g5[c]);
      tx_frame(4 + rnd8() % 8, rep);
      chk("speed_unsupported", cfg_2g5[c] && cfg_spd[c] != PCGD_SPD_1G,
          speed_unsupported);
      rx_frame(rep);
    end
    chk("buffer_full", 1'b1, saw_full);
    end_sim();
  end
endmodule : pcs_client_gmii_datapath_test
`default_nettype wire
